// ===== hw/aar_host_end.sv
// host end: APB-programmed controller issuing device register accesses
// assumes the device answers each request with a one-cycle ack
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_host_end
    import aar_pkg::*;
(
    input  wire logic        pclk,    // system clock
    input  wire logic        presetn, // async reset, low
    input  wire logic        psel,    // apb select
    input  wire logic        penable, // apb access phase
    input  wire logic        pwrite,  // apb direction
    input  wire logic [7:0]  paddr,   // apb byte address
    input  wire logic [31:0] pwdata,  // apb write data
    output logic [31:0]      prdata,  // apb read data
    output logic             pready,  // apb ready
    output logic             pslverr, // unmapped access
    aar_reg_if.host          bus      // register link
);
    // ****************************************************
    // state
    // ****************************************************
    aar_hst_e    st;
    aar_hst_e    next_st;
    aar_op_e     op;
    aar_op_e     next_op;
    logic [2:0]  step;
    logic [2:0]  next_step;
    logic [10:0] addr_r;
    logic [10:0] next_addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  next_wdata_r;
    logic [7:0]  res;
    logic [7:0]  next_res;
    logic        done;
    logic        next_done;
    logic [31:0] prdata_q;
    logic [31:0] next_prdata;
    logic        mapped;
    logic        wr_acc;
    logic        s_wr;
    logic [10:0] s_addr;
    logic [7:0]  s_data;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_q;
    assign wr_acc  = psel & penable & pwrite;
    assign bus.req   = (st == AAR_H_BUSY);
    assign bus.wr    = s_wr;
    assign bus.addr  = s_addr;
    assign bus.wdata = s_data;

    // address decode
    always_comb
    begin
        if (paddr == `AAR_R_CTRL)
            mapped = 1'b1;
        else if (paddr == `AAR_R_ADDR)
            mapped = 1'b1;
        else if (paddr == `AAR_R_WDATA)
            mapped = 1'b1;
        else if (paddr == `AAR_R_STATUS)
            mapped = 1'b1;
        else if (paddr == `AAR_R_RDATA)
            mapped = 1'b1;
        else
            mapped = 1'b0;
    end

    // step table: power up, select sensor, then three reads
    always_comb
    begin
        s_wr   = 1'b0;
        s_addr = `AAR_A_RES_UPPER;
        s_data = 8'h00;
        if (op == AAR_OP_SINGLE)
        begin
            // single op only reads the chosen address
            s_addr = addr_r;
            s_data = wdata_r;
        end
        else if (step == 3'd0)
        begin
            s_wr   = 1'b1;
            s_addr = `AAR_A_RX_PD;
            s_data = `AAR_V_CONV_ON;
        end
        else if (step == 3'd1)
        begin
            s_wr   = 1'b1;
            s_addr = `AAR_A_AUX_PD;
            s_data = `AAR_V_SENSE_ON;
        end
        else if (step == `AAR_STEP_WR_LAST)
        begin
            s_wr   = 1'b1;
            s_addr = `AAR_A_IN_SEL;
            s_data = `AAR_V_SEL_TEMP;
        end
        else if (step == `AAR_STEP_LOW)
            s_addr = `AAR_A_RES_LOWER;
    end

    // apb writes, sequencing, apb read data
    always_comb
    begin
        next_st      = st;
        next_op      = op;
        next_step    = step;
        next_addr_r  = addr_r;
        next_wdata_r = wdata_r;
        next_res     = res;
        next_done    = done;
        next_prdata  = prdata_q;
        if (wr_acc && paddr == `AAR_R_ADDR)
            next_addr_r = pwdata[10:0];
        if (wr_acc && paddr == `AAR_R_WDATA)
            next_wdata_r = pwdata[7:0];
        if (wr_acc && paddr == `AAR_R_STATUS && pwdata[`AAR_B_DONE])
            next_done = 1'b0;
        if (st == AAR_H_IDLE && wr_acc && paddr == `AAR_R_CTRL
            && pwdata[`AAR_B_GO])
        begin
            next_st   = AAR_H_BUSY;
            next_op   = aar_op_e'(pwdata[2:1]);
            next_step = (pwdata[2:1] == 2'd2) ? 3'd3 : 3'd0;
        end
        else if (st == AAR_H_BUSY && bus.ack)
        begin
            if (op == AAR_OP_SINGLE)
            begin
                next_res  = bus.rdata;
                next_done = 1'b1;
                next_st   = AAR_H_IDLE;
            end
            else if (step == `AAR_STEP_LAST)
            begin
                next_res  = {bus.rdata[5:0], res[1:0]};
                next_done = 1'b1;
                next_st   = AAR_H_IDLE;
            end
            else
            begin
                if (step == `AAR_STEP_LOW)
                    next_res = {6'b00_0000, bus.rdata[1:0]};
                next_step = step + 3'd1;
            end
        end
        if (psel && !penable && !pwrite)
        begin
            if (paddr == `AAR_R_CTRL)
                next_prdata = {29'h0, op, 1'b0};
            else if (paddr == `AAR_R_ADDR)
                next_prdata = {21'h0, addr_r};
            else if (paddr == `AAR_R_WDATA)
                next_prdata = {24'h0, wdata_r};
            else if (paddr == `AAR_R_STATUS)
                next_prdata = {30'h0, done, st == AAR_H_BUSY};
            else if (paddr == `AAR_R_RDATA)
                next_prdata = {24'h0, res};
            else
                next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st       <= AAR_H_IDLE;
            op       <= AAR_OP_SINGLE;
            step     <= 3'd0;
            addr_r   <= 11'h000;
            wdata_r  <= 8'h00;
            res      <= 8'h00;
            done     <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            st       <= next_st;
            op       <= next_op;
            step     <= next_step;
            addr_r   <= next_addr_r;
            wdata_r  <= next_wdata_r;
            res      <= next_res;
            done     <= next_done;
            prdata_q <= next_prdata;
        end
    end
endmodule // aar_host_end

// ===== hw/aar_consts.svh
// constants for the aux converter readback block
// assumes inclusion by both ends, the link checker and the bench
`ifndef AAR_CONSTS_SVH
`define AAR_CONSTS_SVH
// device register map (11-bit addresses)
`define AAR_A_RX_PD      11'h324
`define AAR_A_AUX_PD     11'h325
`define AAR_A_RES_UPPER  11'h327
`define AAR_A_RES_LOWER  11'h328
`define AAR_A_IN_SEL     11'h359
// values the host writes to prepare a temperature reading, plus the rssi select code and the reset value
`define AAR_V_CONV_ON    8'h10
`define AAR_V_SENSE_ON   8'h02
`define AAR_V_SEL_TEMP   8'h08
`define AAR_V_SEL_RSSI   8'h04
`define AAR_V_RESET      8'h00
// bit positions
`define AAR_B_CONV_ON    4
`define AAR_B_SENSE_ON   1
// conversion time
`define AAR_CONV_NS      1000
`define AAR_CLK_MHZ      250
`define AAR_CONV_CYC     ((`AAR_CONV_NS * `AAR_CLK_MHZ) / 1000)
// controller APB map
`define AAR_R_CTRL       8'h00
`define AAR_R_ADDR       8'h04
`define AAR_R_WDATA      8'h08
`define AAR_R_STATUS     8'h0C
`define AAR_R_RDATA      8'h10
`define AAR_B_GO         0
`define AAR_B_BUSY       0
`define AAR_B_DONE       1
`define AAR_STEP_WR_LAST 3'd2
`define AAR_STEP_LOW     3'd4
`define AAR_STEP_LAST    3'd5
`endif

// ===== hw/aar_pkg.sv
// types shared by both ends of the converter readback link
// assumes aar_consts.svh is on the include path
package aar_pkg;
    typedef enum logic [1:0] {AAR_OP_SINGLE, AAR_OP_TEMP, AAR_OP_READ,
                              AAR_OP_RSVD} aar_op_e;
    typedef enum logic [1:0] {AAR_RB_IDLE, AAR_RB_LOW, AAR_RB_HIGH}
        aar_rb_e;
    typedef enum logic {AAR_H_IDLE, AAR_H_BUSY} aar_hst_e;
endpackage

// ===== hw/aar_reg_if.sv
// register access link between host controller and device end
// assumes one shared clock; no tristate pins on this link
`timescale 1ns/1ps
interface aar_reg_if;
    logic        req;   // host holds until ack
    logic        wr;    // 1 write, 0 read
    logic [10:0] addr;  // register address
    logic [7:0]  wdata; // write data
    logic        ack;   // one-cycle answer
    logic [7:0]  rdata; // read data, valid with ack
    modport dev  (input req, wr, addr, wdata, output ack, rdata);
    modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface // aar_reg_if

// ===== hw/aar_dev_end.sv
// device end: converter control registers, conversion timer, readback
// assumes analog source codes and receive state arrive on pclk
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_dev_end
    import aar_pkg::*;
(
    input  wire logic       pclk,                // system clock
    input  wire logic       presetn,             // async reset, low
    aar_reg_if.dev          bus,                 // register link
    input  wire logic       radio_receive_state, // radio in receive
    input  wire logic [7:0] temp_sense_code,     // sensor level
    input  wire logic [7:0] rssi_level_code,     // rssi level
    input  wire logic [7:0] ext_input_code,      // external input
    output logic            conv_active,         // converter powered
    output logic [7:0]      conv_sample          // latest result
);
    // ****************************************************
    // register state
    // ****************************************************
    logic [7:0] rx_power_down_ctrl;
    logic [7:0] aux_power_down_ctrl;
    logic [7:0] conv_input_select;
    logic [7:0] next_rx_pd;
    logic [7:0] next_aux_pd;
    logic [7:0] next_sel;
    logic       ack_q;
    logic       next_ack;
    logic [7:0] rdata_q;
    logic [7:0] next_rdata;
    aar_rb_e    rb_phase;
    aar_rb_e    next_rb_phase;
    logic [7:0] held;
    logic [7:0] next_held;
    logic       take;

    // ****************************************************
    // converter state
    // ****************************************************
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] track;
    logic [7:0] next_track;
    logic [7:0] latest;
    logic [7:0] next_latest;
    logic       enabled;
    logic [7:0] src;
    logic       active_q;

    assign bus.ack     = ack_q;
    assign bus.rdata   = rdata_q;
    // power flag leaves a flop; it trails the receive input by one cycle,
    // which nothing downstream of this block can notice
    assign conv_active = active_q;
    assign conv_sample = latest;
    // a request is taken once; the ack cycle blocks a second take
    // one request in flight: the ack cycle doubles as the idle slot
    assign take = bus.req & ~ack_q;

    // power and source choice; receive state overrides software
    // every select code other than temperature or rssi means external
    always_comb
    begin
        enabled = radio_receive_state
                | rx_power_down_ctrl[`AAR_B_CONV_ON];
        if (radio_receive_state)
            src = rssi_level_code;
        else if (conv_input_select == `AAR_V_SEL_TEMP)
            // unpowered sensor gives no signal
            src = aux_power_down_ctrl[`AAR_B_SENSE_ON]
                ? temp_sense_code : `AAR_V_RESET;
        else if (conv_input_select == `AAR_V_SEL_RSSI)
            src = rssi_level_code;
        else
            src = ext_input_code;
    end

    // free-running conversions while powered; source sampled at start
    // the source is taken once per conversion, so a select change or a
    // receive entry lands on the next sample, never half-way through
    always_comb
    begin
        next_cnt    = cnt;
        next_track  = track;
        next_latest = latest;
        if (!enabled)
            next_cnt = 8'h00;
        else if (cnt == 8'(`AAR_CONV_CYC - 1))
        begin
            next_cnt    = 8'h00;
            next_latest = track;
        end
        else
        begin
            if (cnt == 8'h00)
                next_track = src;
            next_cnt = cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt      <= 8'h00;
            track    <= 8'h00;
            latest   <= 8'h00;
            active_q <= 1'b0;
        end
        else
        begin
            cnt      <= next_cnt;
            track    <= next_track;
            latest   <= next_latest;
            active_q <= enabled;
        end
    end

    // register access, readback sequence and its held sample
    // a lower read outside a sequence still returns the held fragment;
    // software that skips the opening upper read gets a stale sample
    always_comb
    begin
        next_rx_pd    = rx_power_down_ctrl;
        next_aux_pd   = aux_power_down_ctrl;
        next_sel      = conv_input_select;
        next_rb_phase = rb_phase;
        next_held     = held;
        next_rdata    = rdata_q;
        next_ack      = take;
        if (take && bus.wr)
        begin
            // result registers are read-only; unmapped writes dropped
            if (bus.addr == `AAR_A_RX_PD)
                next_rx_pd = bus.wdata;
            else if (bus.addr == `AAR_A_AUX_PD)
                next_aux_pd = bus.wdata;
            else if (bus.addr == `AAR_A_IN_SEL)
                next_sel = bus.wdata;
            next_rdata = 8'h00;
        end
        else if (take)
        begin
            if (bus.addr == `AAR_A_RX_PD)
                next_rdata = rx_power_down_ctrl;
            else if (bus.addr == `AAR_A_AUX_PD)
                next_rdata = aux_power_down_ctrl;
            else if (bus.addr == `AAR_A_IN_SEL)
                next_rdata = conv_input_select;
            else if (bus.addr == `AAR_A_RES_UPPER)
            begin
                if (rb_phase == AAR_RB_HIGH)
                begin
                    next_rdata    = {2'b00, held[7:2]};
                    next_rb_phase = AAR_RB_IDLE;
                end
                else
                begin
                    // any other upper read restarts the sequence
                    next_held     = latest;
                    next_rdata    = {2'b00, latest[7:2]};
                    next_rb_phase = AAR_RB_LOW;
                end
            end
            else if (bus.addr == `AAR_A_RES_LOWER)
            begin
                next_rdata = {6'b00_0000, held[1:0]};
                if (rb_phase == AAR_RB_LOW)
                    next_rb_phase = AAR_RB_HIGH;
            end
            else
                next_rdata = 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_power_down_ctrl  <= `AAR_V_RESET;
            aux_power_down_ctrl <= `AAR_V_RESET;
            conv_input_select   <= `AAR_V_RESET;
            rb_phase            <= AAR_RB_IDLE;
            held                <= 8'h00;
            rdata_q             <= 8'h00;
            ack_q               <= 1'b0;
        end
        else
        begin
            rx_power_down_ctrl  <= next_rx_pd;
            aux_power_down_ctrl <= next_aux_pd;
            conv_input_select   <= next_sel;
            rb_phase            <= next_rb_phase;
            held                <= next_held;
            rdata_q             <= next_rdata;
            ack_q               <= next_ack;
        end
    end
endmodule // aar_dev_end

// ===== tb/aar_link_props.sv
// checker for the register link between host end and device end
// assumes one clock; instantiated beside the link in the bench
`timescale 1ns/1ps
`include "aar_consts.svh"
module aar_link_props (
    input wire logic        pclk,    // system clock
    input wire logic        presetn, // async reset, low
    input wire logic        req,     // host request
    input wire logic        wr,      // direction
    input wire logic [10:0] addr,    // register address
    input wire logic [7:0]  wdata,   // write data
    input wire logic        ack,     // device answer
    input wire logic [7:0]  rdata    // read data
);
    // ****************************************
    // link properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ack_pulse; ack |=> !ack; endproperty
    property p_ack_take; req && !ack |=> ack; endproperty
    property p_ack_cause; ack |-> $past(req); endproperty
    // request must not move while waiting for the answer
    property p_req_hold;
        req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
    endproperty
    property p_rdata_hold; !ack |-> $stable(rdata); endproperty
    property p_lower_bits;
        ack && !$past(wr) && $past(addr) == `AAR_A_RES_LOWER
            |-> rdata[7:2] == 6'h0;
    endproperty
    property p_upper_bits;
        ack && !$past(wr) && $past(addr) == `AAR_A_RES_UPPER
            |-> rdata[7:6] == 2'h0;
    endproperty
    property p_conv_on_val;
        req && wr && addr == `AAR_A_RX_PD |-> wdata == `AAR_V_CONV_ON;
    endproperty
    // temperature setup keeps its order, one step after each answer
    property p_aux_next;
        ack && $past(wr) && $past(addr) == `AAR_A_RX_PD |=> req && wr
            && addr == `AAR_A_AUX_PD && wdata == `AAR_V_SENSE_ON;
    endproperty
    property p_sel_next;
        ack && $past(wr) && $past(addr) == `AAR_A_AUX_PD |=> req && wr
            && addr == `AAR_A_IN_SEL && wdata == `AAR_V_SEL_TEMP;
    endproperty
    property p_read_next;
        ack && $past(wr) && $past(addr) == `AAR_A_IN_SEL
            |=> req && !wr && addr == `AAR_A_RES_UPPER;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_ack_take: assert property (p_ack_take)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_req_hold: assert property (p_req_hold)
        else $error("request changed before ack");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without ack");
    a_lower_bits: assert property (p_lower_bits)
        else $error("lower result wider than two bits");
    a_upper_bits: assert property (p_upper_bits)
        else $error("upper result wider than six bits");
    a_conv_on_val: assert property (p_conv_on_val)
        else $error("wrong converter enable value");
    a_aux_next: assert property (p_aux_next)
        else $error("sensor power not second");
    a_sel_next: assert property (p_sel_next)
        else $error("input select not third");
    a_read_next: assert property (p_read_next)
        else $error("readback not after setup");
    c_lower: cover property (ack && $past(addr) == `AAR_A_RES_LOWER);
    c_setup: cover property (req && wr && addr == `AAR_A_IN_SEL);
    c_upper: cover property (ack && $past(addr) == `AAR_A_RES_UPPER);
endmodule // aar_link_props

// ===== tb/aux_adc_readback_temp_sense_bench.sv
// bench: APB drives the host end, which talks to the device end
// assumes one 250 MHz clock and the link interface between the ends
`timescale 1ns/1ps
`include "aar_consts.svh"
module aux_adc_readback_temp_sense_bench;
    // ****************************************
    // wiring
    // ****************************************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_active;
    logic        rx_on = 1'b0;
    logic [7:0]  temp_code = 8'h00;
    logic [7:0]  rssi_code = 8'h00;
    logic [7:0]  ext_code = 8'h00;
    logic [7:0]  conv_sample;
    logic [32:0] exp_q[$];
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;
    aar_reg_if link ();
    aar_host_end i_aar_host_end (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(link.host));
    aar_dev_end i_aar_dev_end (.pclk(pclk), .presetn(presetn),
        .bus(link.dev), .radio_receive_state(rx_on),
        .temp_sense_code(temp_code), .rssi_level_code(rssi_code),
        .ext_input_code(ext_code), .conv_active(conv_active),
        .conv_sample(conv_sample));
    aar_link_props i_aar_link_props (.pclk(pclk), .presetn(presetn),
        .req(link.req), .wr(link.wr), .addr(link.addr),
        .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
    always #2 pclk = ~pclk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(string name, logic [32:0] seen, logic [32:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one APB transfer; an idle edge first so psel never toggles twice
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_exp(logic [7:0] a, logic [32:0] e);
        logic [31:0] r;
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000, r);
    endtask
    // start an op, wait for sticky done, then clear it
    task automatic run_op(logic [1:0] op);
        logic [31:0] r;
        apb(1'b1, `AAR_R_CTRL, {29'h0, op, 1'b1}, r);
        r = 32'h0000_0000;
        while (r[`AAR_B_DONE] !== 1'b1)
            apb(1'b0, `AAR_R_STATUS, 32'h0000_0000, r);
        apb(1'b1, `AAR_R_STATUS, 32'h0000_0002, r);
    endtask
    task automatic single(logic [10:0] a, logic [7:0] e);
        logic [31:0] r;
        apb(1'b1, `AAR_R_ADDR, {21'h0, a}, r);
        run_op(2'd0);
        rd_exp(`AAR_R_RDATA, {25'h0, e});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // watcher and sequence
    // ****************************************
    // reads complete at the pready edge; compare against oldest note
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            chk("apb read", {pslverr, prdata}, exp_q.pop_front());
    // cycle ceiling well above the roughly 2000 cycles needed
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        void'($urandom(32'h9771));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        temp_code <= 8'($urandom());
        rssi_code <= 8'($urandom());
        ext_code <= 8'($urandom());
        single(`AAR_A_RX_PD, `AAR_V_RESET);
        single(11'h3FF, 8'h00);
        rd_exp(8'h20, {1'b1, 32'h0000_0000});
        // setup then an immediate readback: nothing converted yet
        run_op(2'd1);
        rd_exp(`AAR_R_RDATA, 33'h0_0000_0000);
        chk("conv_active", {32'h0, conv_active}, 33'h1);
        single(`AAR_A_AUX_PD, `AAR_V_SENSE_ON);
        single(`AAR_A_IN_SEL, `AAR_V_SEL_TEMP);
        repeat (600) @(posedge pclk);
        chk("conv_sample", {25'h0, conv_sample}, {25'h0, temp_code});
        run_op(2'd2);
        rd_exp(`AAR_R_RDATA, {25'h0, temp_code});
        rd_exp(`AAR_R_CTRL, 33'h0_0000_0004);
        rd_exp(`AAR_R_STATUS, 33'h0_0000_0000);
        single(`AAR_A_RES_LOWER, {6'h0, temp_code[1:0]});
        // a later reading of a new random sensor code
        temp_code <= 8'($urandom());
        repeat (600) @(posedge pclk);
        run_op(2'd2);
        rd_exp(`AAR_R_RDATA, {25'h0, temp_code});
        // receive overrides the temperature select
        @(posedge pclk);
        rx_on <= 1'b1;
        repeat (600) @(posedge pclk);
        chk("conv_active rx", {32'h0, conv_active}, 33'h1);
        run_op(2'd2);
        rd_exp(`AAR_R_RDATA, {25'h0, rssi_code});
        @(posedge pclk);
        give_verdict();
    end
endmodule // aux_adc_readback_temp_sense_bench
